// ===== verilog/fsiap_pkg.sv
// Package for the flash security and in-application programming sequencer.
// Assumes a single 100 MHz clock domain and an SFR-style byte bus.
package fsiap_pkg;
  localparam logic [7:0] FSIAP_ADDR_CMD = 8'hd5;
  localparam logic [7:0] FSIAP_ADDR_DATA = 8'hd6;
  localparam int FSIAP_IDLE_BIT = 7;
  localparam int FSIAP_FAULT_BIT = 6;
  localparam int FSIAP_WDOG_BIT = 3;
  localparam int FSIAP_LOCK_LSB = 3;
  localparam logic [7:0] FSIAP_LOCK_ADDR = 8'h40;
  localparam logic [7:0] FSIAP_SIG_MFR_ADDR = 8'h30;
  localparam logic [7:0] FSIAP_SIG_PART_ADDR = 8'h31;
  localparam logic [7:0] FSIAP_SIG_EXT_ADDR = 8'h60;
  localparam logic [7:0] FSIAP_ERASED = 8'hff;
  localparam logic [3:0] FSIAP_CMD_RESET = 4'h0;
  localparam int FSIAP_CLK_MHZ = 100;
  localparam int FSIAP_START_NS = 1000;
  localparam int FSIAP_START_CYC = (FSIAP_START_NS * FSIAP_CLK_MHZ) / 1000;
  localparam int FSIAP_PROG_NS = 20000;
  localparam int FSIAP_PROG_CYC = (FSIAP_PROG_NS * FSIAP_CLK_MHZ) / 1000;
  localparam int FSIAP_AW = 13;

  typedef enum logic [3:0] {
    FSIAP_C_READ = 4'h0, FSIAP_C_VOPT = 4'h1, FSIAP_C_VSEC = 4'h2, FSIAP_C_VUPR = 4'h3,
    FSIAP_C_WOPT = 4'h9, FSIAP_C_WSEC = 4'ha, FSIAP_C_WUPR = 4'hb, FSIAP_C_EOPT = 4'hc,
    FSIAP_C_ESEC = 4'hd, FSIAP_C_EUPR = 4'he, FSIAP_C_SRST = 4'hf
  } fsiap_cmd_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fsiap_bus_s;

  typedef struct packed {
    logic req;
    logic erase;
    logic [FSIAP_AW-1:0] addr;
    logic [7:0] data;
  } fsiap_cell_s;
endpackage

// ===== verilog/fsiap_timer.sv
// Self-timed operation engine: start delay then busy period, with fault input.
// Assumes the request pulse arrives only while idle.
`timescale 1ns/10ps
`default_nettype none
module fsiap_timer
  import fsiap_pkg::*;
#(
  parameter int START_CYC = FSIAP_START_CYC,
  parameter int PROG_CYC = FSIAP_PROG_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic cellFault,
  output logic idle,
  output logic done,
  output logic failed
);
  typedef enum logic [1:0] {FSIAP_T_IDLE = 2'b00, FSIAP_T_WAIT = 2'b01,
                            FSIAP_T_RUN = 2'b11} fsiap_tst_e;
  fsiap_tst_e st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  wire logic cntEnd = (cnt_r == 16'h0000);
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cntEnd ? cnt_r : cnt_r - 16'h0001;
    unique case (st_r)
      FSIAP_T_IDLE: if (go) begin
        st_nxt = FSIAP_T_WAIT;
        cnt_nxt = 16'(START_CYC - 1);
      end
      FSIAP_T_WAIT: if (cntEnd) begin
        st_nxt = FSIAP_T_RUN;
        cnt_nxt = 16'(PROG_CYC - 1);
      end
      FSIAP_T_RUN: if (cntEnd || cellFault) st_nxt = FSIAP_T_IDLE;
      default: st_nxt = FSIAP_T_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= FSIAP_T_IDLE;
      cnt_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  // Idle stays high during the start delay, as allowed up to 1 us
  assign idle = (st_r != FSIAP_T_RUN); // RULE15
  assign done = (st_r == FSIAP_T_RUN) && (cntEnd || cellFault);
  assign failed = (st_r == FSIAP_T_RUN) && cellFault;
endmodule
`default_nettype wire

// ===== verilog/fsiap_top.sv
// Flash security and in-application programming sequencer.
// Assumes byte SFR accesses on the system clock and a timed-access qualifier
// from the core; the upper bank cell array is modelled by flip-flops.
// Behaviour
// RULE1: Programmed encryption array XNORs verify data
// RULE2: Low six address bits pick key byte
// RULE3: All lock bits one: encryption only
// RULE4: Lock one: block table reads, latch pin
// RULE5: Lock two: no verify, no data moves
// RULE6: Lock three: no external execution
// RULE7: Lock bits clear only by erase
// RULE8: Option bit three sets watchdog default
// RULE9: Other option bits read as one
// RULE10: Signature bytes readable in loader modes
// RULE11: Locks gate loader access, not IAP
// RULE12: Command write enables data port access
// RULE13: Program and erase hit upper bank
// RULE14: Final data byte starts the operation
// RULE15: Idle flag drops during operation
// RULE16: Failure aborts and sets fault flag
// RULE17: Software reissues command every operation
// RULE18: Program byte sequence with idle checks
// RULE19: Nonzero command blocks upper bank execution
// RULE20: Command one returns option byte
// RULE21: Command two returns security byte
// RULE22: Reset clears command field to zero
// RULE23: Timed writes only, ignored while busy
// RULE24: Program takes high, low, data
// RULE25: Erase sets upper bank to ones
// RULE26: Accepted command clears fault flag
`timescale 1ns/10ps
`default_nettype none
module fsiap_top
  import fsiap_pkg::*;
#(
  parameter int START_CYC = FSIAP_START_CYC,
  parameter int PROG_CYC = FSIAP_PROG_CYC,
  parameter int BANK_DEPTH = 64,
  parameter logic [7:0] MFR_ID = 8'h5a,
  parameter logic [7:0] PART_ID = 8'h11,
  parameter logic [7:0] EXT_ID = 8'h22
) (
  input wire logic clk,
  input wire logic rst,
  input wire fsiap_bus_s sfr,
  input wire logic timedOk,
  output logic [7:0] sfrRdata,
  input wire logic loaderMode,
  input wire logic externalAccessPin,
  input wire logic cellFault,
  input wire logic extTableRead,
  input wire logic extDataMove,
  input wire logic fetchUpper,
  output logic tableReadAllow,
  output logic dataMoveAllow,
  output logic extExecAllow,
  output logic upperExecAllow,
  output logic loaderVerifyAllow,
  output logic loaderProgAllow,
  output logic externalAccessLatched,
  output logic watchdogPorEnable,
  output logic sysResetReq,
  output logic [7:0] loaderData,
  input wire logic [7:0] loaderAddr
);
  localparam int KW = $clog2(BANK_DEPTH);
  fsiap_cmd_e cmd_r;
  logic fault_r;
  logic [7:0] data_r;
  logic [1:0] step_r;
  logic [7:0] addrHi_r, addrLo_r;
  logic [7:0] option_r;
  logic [2:0] lock_r;
  logic [7:0] key_r [64];
  logic [7:0] bank_r [BANK_DEPTH];
  logic eaLatch_r, rstSeen_r;
  logic keyErased_r;
  logic pendErase_r, pendWrite_r;
  logic [KW-1:0] pendAddr_r;
  logic [7:0] pendData_r;
  logic opGo, idle, opDone, opFail;

  fsiap_timer #(.START_CYC(START_CYC), .PROG_CYC(PROG_CYC)) uTimer (
    .clk(clk), .rst(rst), .go(opGo), .cellFault(cellFault),
    .idle(idle), .done(opDone), .failed(opFail)
  );

  wire logic cmdWr = sfr.wr && sfr.addr == FSIAP_ADDR_CMD;
  // Idle stays high through the start delay, so the staged operation marks busy
  wire logic opBusy = pendErase_r || pendWrite_r;
  wire logic cmdTake = cmdWr && timedOk && idle && !opBusy; // RULE23
  wire logic dataWr = sfr.wr && sfr.addr == FSIAP_ADDR_DATA && cmd_r != FSIAP_C_READ; // RULE12
  wire logic [15:0] fullAddr = {addrHi_r, addrLo_r};
  // Verify address: its low byte arrives with the final data port write
  wire logic [15:0] pgmAddr = {addrHi_r, sfr.wdata};
  wire logic [KW-1:0] bankIdx = KW'(fullAddr);
  wire logic [5:0] keySel = pgmAddr[5:0]; // RULE2
  wire logic [7:0] vfyRaw = bank_r[KW'(pgmAddr)];
  wire logic [7:0] vfyKey = key_r[keySel];
  wire logic [7:0] vfyOut = keyErased_r ? vfyRaw : ~(vfyRaw ^ vfyKey); // RULE1 RULE3
  // Verify shows lock one at bit five, the reverse of the write order
  wire logic [7:0] secByte = (sfr.wdata == FSIAP_LOCK_ADDR) ?
    {2'b11, lock_r[0], lock_r[1], lock_r[2], 3'b111} : key_r[keySel]; // RULE21
  wire logic [7:0] optView = {4'hf, option_r[FSIAP_WDOG_BIT], 3'h7}; // RULE9
  wire logic lvl2 = !lock_r[0] || !lock_r[1] || !lock_r[2];
  wire logic lvl3 = !lock_r[1] || !lock_r[2];
  wire logic lvl4 = !lock_r[2];
  wire logic lastByte = (cmd_r == FSIAP_C_WUPR && step_r == 2'd2) ||
                        (cmd_r == FSIAP_C_WSEC && step_r == 2'd1) ||
                        (cmd_r == FSIAP_C_WOPT && step_r == 2'd0);
  wire logic eraseStart = cmdTake && (sfr.wdata[3:0] == FSIAP_C_EUPR ||
    sfr.wdata[3:0] == FSIAP_C_ESEC || sfr.wdata[3:0] == FSIAP_C_EOPT);

  assign opGo = (dataWr && lastByte && idle) || eraseStart; // RULE14
  assign sfrRdata = (sfr.addr == FSIAP_ADDR_CMD) ?
    {idle, fault_r, 2'b00, cmd_r} : (sfr.addr == FSIAP_ADDR_DATA) ? data_r : 8'h00;

  // Lock bits steer core-side permissions; upper bank execution follows the command field
  assign tableReadAllow = !(lvl2 && extTableRead); // RULE4
  assign dataMoveAllow = !(lvl3 && extDataMove); // RULE5
  assign extExecAllow = !lvl4 && externalAccessLatched; // RULE6
  assign upperExecAllow = !(fetchUpper && cmd_r != FSIAP_C_READ); // RULE19
  // Loader paths are gated by locks; IAP paths above ignore them
  assign loaderProgAllow = loaderMode && !lvl2; // RULE11 RULE4
  assign loaderVerifyAllow = loaderMode && !lvl3; // RULE11 RULE5
  assign externalAccessLatched = lvl2 ? eaLatch_r : externalAccessPin; // RULE4
  assign watchdogPorEnable = !option_r[FSIAP_WDOG_BIT]; // RULE8
  assign sysResetReq = cmd_r == FSIAP_C_SRST;
  assign loaderData = !loaderMode ? 8'h00 :
    (loaderAddr == FSIAP_SIG_MFR_ADDR) ? MFR_ID :
    (loaderAddr == FSIAP_SIG_PART_ADDR) ? PART_ID :
    (loaderAddr == FSIAP_SIG_EXT_ADDR) ? EXT_ID : 8'hff; // RULE10

  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_r <= FSIAP_C_READ; // RULE22
      step_r <= 2'd0;
      rstSeen_r <= 1'b0;
    end else begin
      if (cmdTake) begin
        cmd_r <= fsiap_cmd_e'(sfr.wdata[3:0]);
        step_r <= 2'd0;
      end else if (dataWr && idle && step_r != 2'd3) begin
        // Step saturates after the last byte so a reused command starts no further operation
        step_r <= lastByte ? 2'd3 : step_r + 2'd1; // RULE17
      end
      rstSeen_r <= 1'b1;
    end
  end

  // External access pin is caught in the first cycle after reset release
  always_ff @(posedge clk) begin
    if (!rstSeen_r) eaLatch_r <= externalAccessPin; // RULE4
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fault_r <= 1'b0;
    end else if (opFail) begin
      fault_r <= 1'b1; // RULE16
    end else if (cmdTake) begin
      fault_r <= 1'b0; // RULE26
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      data_r <= 8'h00;
      addrHi_r <= 8'h00;
      addrLo_r <= 8'h00;
    end else if (cmdTake && sfr.wdata[3:0] == FSIAP_C_VOPT) begin
      data_r <= optView; // RULE20
    end else if (dataWr) begin
      data_r <= sfr.wdata;
      if (step_r == 2'd0) addrHi_r <= sfr.wdata;
      if (step_r == 2'd1) addrLo_r <= sfr.wdata; // RULE24
      if (cmd_r == FSIAP_C_VSEC && step_r == 2'd0) data_r <= secByte;
      if (cmd_r == FSIAP_C_VUPR && step_r == 2'd1) begin
        data_r <= vfyOut; // RULE1
        if (loaderMode && lvl3) data_r <= 8'hff; // RULE5
      end
    end
  end

  // Writes are staged and committed when the timed operation ends cleanly
  always_ff @(posedge clk) begin
    if (rst) begin
      pendErase_r <= 1'b0;
      pendWrite_r <= 1'b0;
      pendAddr_r <= '0;
      pendData_r <= 8'h00;
    end else if (opGo) begin
      pendErase_r <= eraseStart;
      pendWrite_r <= !eraseStart;
      pendAddr_r <= bankIdx; // RULE13
      pendData_r <= sfr.wdata;
    end else if (opDone) begin
      pendErase_r <= 1'b0;
      pendWrite_r <= 1'b0;
    end
  end

  wire logic commit = opDone && !opFail;

  // Flash cells: no power-up value is loaded, so software erases first; resets do not touch them
  always_ff @(posedge clk) begin
    if (commit && cmd_r == FSIAP_C_EOPT) option_r <= FSIAP_ERASED;
    else if (commit && cmd_r == FSIAP_C_WOPT) option_r <= option_r & pendData_r; // RULE8
  end

  always_ff @(posedge clk) begin
    if (commit && cmd_r == FSIAP_C_ESEC) begin
      lock_r <= 3'b111; // RULE7
    end else if (commit && cmd_r == FSIAP_C_WSEC && addrHi_r == FSIAP_LOCK_ADDR) begin
      lock_r <= lock_r & pendData_r[FSIAP_LOCK_LSB +: 3]; // RULE7
    end
  end

  always_ff @(posedge clk) begin
    if (commit && cmd_r == FSIAP_C_ESEC) keyErased_r <= 1'b1;
    else if (commit && cmd_r == FSIAP_C_WSEC && addrHi_r < FSIAP_LOCK_ADDR &&
             pendData_r != FSIAP_ERASED) keyErased_r <= 1'b0;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 64; gi++) begin : gKey
      always_ff @(posedge clk) begin
        if (commit && cmd_r == FSIAP_C_ESEC) key_r[gi] <= FSIAP_ERASED;
        else if (commit && cmd_r == FSIAP_C_WSEC && addrHi_r == 8'(gi))
          key_r[gi] <= key_r[gi] & pendData_r;
      end
    end
    for (gi = 0; gi < BANK_DEPTH; gi++) begin : gBank
      always_ff @(posedge clk) begin
        if (commit && pendErase_r && cmd_r == FSIAP_C_EUPR) begin
          bank_r[gi] <= FSIAP_ERASED; // RULE25 RULE13
        end else if (commit && pendWrite_r && cmd_r == FSIAP_C_WUPR &&
                     pendAddr_r == KW'(gi)) begin
          bank_r[gi] <= bank_r[gi] & pendData_r; // RULE24
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ===== sim/fsiap_top_sva.sv
// Port checker for the flash sequencer top.
// Assumes one clock domain and the synchronous reset of the top.
`timescale 1ns/10ps
`default_nettype none
module fsiap_top_chk
  import fsiap_pkg::*;
#(
  parameter logic [7:0] MFR_ID = 8'h5a,
  parameter logic [7:0] PART_ID = 8'h11
) (
  input wire logic clk,
  input wire logic rst,
  input wire fsiap_bus_s sfr,
  input wire logic loaderMode,
  input wire logic extTableRead,
  input wire logic extDataMove,
  input wire logic [7:0] loaderAddr,
  input wire logic [7:0] sfrRdata,
  input wire logic [7:0] loaderData,
  input wire logic tableReadAllow,
  input wire logic dataMoveAllow,
  input wire logic extExecAllow,
  input wire logic upperExecAllow,
  input wire logic loaderVerifyAllow,
  input wire logic loaderProgAllow
);
  wire rdCmd = sfr.rd && sfr.addr == FSIAP_ADDR_CMD;
  wire rdData = sfr.rd && sfr.addr == FSIAP_ADDR_DATA;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  reset_status_a: assert property ($past(rst) && rdCmd |-> sfrRdata == 8'h80)
    else $error("status after reset wrong");
  reset_data_a: assert property ($past(rst) && rdData |-> sfrRdata == 8'h00)
    else $error("data port after reset wrong");
  unmapped_zero_a: assert property (sfr.rd && !rdCmd && !rdData |-> sfrRdata == 8'h00)
    else $error("unmapped read not zero");
  status_gap_a: assert property (rdCmd |-> sfrRdata[5:4] == 2'b00)
    else $error("status spare bits set");
  busy_exec_a: assert property (rdCmd && sfrRdata[3:0] != 4'h0 |-> !upperExecAllow)
    else $error("upper bank runnable with command set");
  move_nest_a: assert property (extTableRead && !dataMoveAllow |-> !tableReadAllow)
    else $error("table read open above level two");
  exec_nest_a: assert property (extDataMove && !extExecAllow |-> !dataMoveAllow)
    else $error("data move open at level four");
  loader_nest_a: assert property (loaderMode && !loaderVerifyAllow |-> !loaderProgAllow)
    else $error("loader program open at level three");
  sig_maker_a: assert property (loaderMode && loaderAddr == 8'h30 |-> loaderData == MFR_ID)
    else $error("maker signature wrong");
  sig_part_a: assert property (loaderMode && loaderAddr == 8'h31 |-> loaderData == PART_ID)
    else $error("part signature wrong");
endmodule
bind fsiap_top fsiap_top_chk #(.MFR_ID(MFR_ID), .PART_ID(PART_ID)) chk (.clk, .rst, .sfr,
  .loaderMode, .extTableRead, .extDataMove, .loaderAddr, .sfrRdata, .loaderData,
  .tableReadAllow, .dataMoveAllow, .extExecAllow, .upperExecAllow, .loaderVerifyAllow,
  .loaderProgAllow);
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench for the flash sequencer top.
// Assumes short start and busy counts so each operation ends within six cycles.
`timescale 1ns/10ps
`default_nettype none
module testbench
  import fsiap_pkg::*;
;
  logic clk = 0;
  logic rst = 1;
  fsiap_bus_s sfr = '0;
  logic timedOk = 0;
  logic loaderMode = 0;
  logic cellFault = 0;
  logic [7:0] loaderAddr = '0;
  logic [7:0] sfrRdata, loaderData;
  logic externalAccessPin = 1;
  logic fetchUpper = 1;
  logic tra, dma, eea, uea, lva, lpa, wdog, eal, srst;
  int failures = 0;
  int checked = 0;
  // Identity values are arbitrary
  logic [7:0] sigA[3] = '{8'h30, 8'h31, 8'h60};
  logic [7:0] sigE[3] = '{8'h5a, 8'h11, 8'h22};
  // Lock byte as written (bit five is lock three), then {tra, dma, eea, lva, lpa}
  logic [12:0] rows[4] = '{{8'hff, 5'h1f}, {8'hf7, 5'h0e}, {8'he7, 5'h04}, {8'hc7, 5'h00}};
  fsiap_top #(.START_CYC(2), .PROG_CYC(4)) dut (
    .clk, .rst, .sfr, .timedOk, .sfrRdata, .loaderMode, .externalAccessPin, .cellFault,
    .extTableRead(1'b1), .extDataMove(1'b1), .fetchUpper, .tableReadAllow(tra),
    .dataMoveAllow(dma), .extExecAllow(eea), .upperExecAllow(uea), .loaderVerifyAllow(lva),
    .loaderProgAllow(lpa), .externalAccessLatched(eal), .watchdogPorEnable(wdog),
    .sysResetReq(srst), .loaderData, .loaderAddr);
  always #5 clk = ~clk;
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic t);
    @(posedge clk);
    #1;
    sfr = {w, !w, a, d};
    timedOk = t;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    acc(0, a, 8'h00, 0);
    #1;
    chk(nm, sfrRdata, e);
  endtask
  // Bounded polls so a stuck idle flag cannot hang; only one stuck low ends in a mismatch
  task automatic opWait;
    int n;
    n = 0;
    #1;
    for (int p = 0; p < 2; p++) begin
      while (sfrRdata[7] !== p[0] && n < 40 * (p + 1)) begin
        acc(0, FSIAP_ADDR_CMD, 8'h00, 0);
        #1;
        n++;
      end
    end
    chk("opdone", 8'(n < 80), 8'h01);
  endtask
  task automatic op(input logic [3:0] c, input int n, input logic [23:0] b, input logic w);
    acc(1, FSIAP_ADDR_CMD, {4'h0, c}, 1);
    for (int i = 0; i < n; i++) begin
      acc(1, FSIAP_ADDR_DATA, b[23-8*i -: 8], 0);
    end
    acc(0, FSIAP_ADDR_CMD, 8'h00, 0);
    if (w) opWait();
  endtask
  task automatic final_report;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 0;
    sfr = {1'b0, 1'b1, FSIAP_ADDR_DATA, 8'h00};
    rdc("status", FSIAP_ADDR_CMD, 8'h80);
    acc(1, FSIAP_ADDR_DATA, 8'h77, 0);
    rdc("data", FSIAP_ADDR_DATA, 8'h00);
    rdc("unmapped", 8'h00, 8'h00);
    acc(1, FSIAP_ADDR_CMD, 8'h01, 0);
    rdc("untimed", FSIAP_ADDR_CMD, 8'h80);
    op(4'hc, 0, 0, 1);
    op(4'h1, 0, 0, 0);
    rdc("opt", FSIAP_ADDR_DATA, 8'hff);
    chk("wdog", 8'(wdog), 8'h00);
    op(4'h9, 1, 24'h000000, 1);
    op(4'h1, 0, 0, 0);
    rdc("opt", FSIAP_ADDR_DATA, 8'hf7);
    chk("wdog", 8'(wdog), 8'h01);
    op(4'hd, 0, 0, 0);
    repeat (3) acc(0, FSIAP_ADDR_CMD, 8'h00, 0);
    acc(1, FSIAP_ADDR_CMD, 8'h01, 1);
    opWait();
    rdc("busycmd", FSIAP_ADDR_CMD, 8'h8d);
    loaderMode = 1;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      #1 loaderAddr = sigA[i];
      #1 chk("sig", loaderData, sigE[i]);
    end
    loaderMode = 0;
    foreach (rows[i]) begin
      op(4'ha, 2, {8'h40, rows[i][12:5], 8'h00}, 1);
      // Pin drops once a lock is set: the latched level must hold
      externalAccessPin = (i == 0);
      loaderMode = 1;
      #1 chk("locks", {2'b00, eal, tra, dma, eea, lva, lpa}, {3'b001, rows[i][4:0]});
      loaderMode = 0;
      op(4'h2, 1, 24'h400000, 0);
      rdc("lkv", FSIAP_ADDR_DATA, {2'b11, rows[i][8], rows[i][9], rows[i][10], 3'b111});
    end
    externalAccessPin = 1;
    op(4'h2, 1, 24'h400000, 0);
    rdc("lockrd", FSIAP_ADDR_DATA, 8'hc7);
    op(4'hd, 0, 0, 1);
    chk("unlock", {3'b000, tra, dma, eea, lva, lpa}, 8'h1c);
    op(4'he, 0, 0, 1);
    op(4'hb, 3, 24'h20053c, 1);
    rdc("prog", FSIAP_ADDR_CMD, 8'h8b);
    chk("uexec", 8'(uea), 8'h00);
    op(4'h3, 2, 24'h200500, 0);
    rdc("plain", FSIAP_ADDR_DATA, 8'h3c);
    op(4'ha, 2, 24'h050f00, 1);
    op(4'h3, 2, 24'h200500, 0);
    rdc("crypt", FSIAP_ADDR_DATA, 8'hcc);
    cellFault = 1;
    op(4'hb, 3, 24'h200700, 1);
    cellFault = 0;
    rdc("fault", FSIAP_ADDR_CMD, 8'hcb);
    acc(1, FSIAP_ADDR_CMD, 8'h00, 1);
    rdc("clear", FSIAP_ADDR_CMD, 8'h80);
    chk("uexec", 8'(uea), 8'h01);
    acc(1, FSIAP_ADDR_CMD, 8'h0f, 1);
    rdc("srstcmd", FSIAP_ADDR_CMD, 8'h8f);
    chk("srst", 8'(srst), 8'h01);
    fetchUpper = 0;
    #1 chk("uexec", 8'(uea), 8'h01);
    fetchUpper = 1;
    // Mid-run reset with a command and a data word left standing
    op(4'h2, 1, 24'h400000, 0);
    rst = 1;
    @(posedge clk);
    #1 rst = 0;
    rdc("rststat", FSIAP_ADDR_CMD, 8'h80);
    rdc("rstdata", FSIAP_ADDR_DATA, 8'h00);
    chk("srst", 8'(srst), 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
